// [clrb_params.svh]
`ifndef CLRB_PARAMS_SVH
`define CLRB_PARAMS_SVH
// register offsets
`define CLRB_OFS_CELL_V   8'h00
`define CLRB_OFS_CHG_I    8'h01
`define CLRB_OFS_IN_V     8'h02
`define CLRB_LAST_OFS     8'h02
// reset values
`define CLRB_RST_CELL_V   8'hA0
`define CLRB_RST_CHG_I    8'h5E
`define CLRB_RST_IN_V     8'h84
// field positions, input voltage register
`define CLRB_IV_PLUGRST   7
`define CLRB_IV_DISCHG    6
`define CLRB_IV_OOA_DIS   5
// field positions, charge current register
`define CLRB_CI_HIZ       7
`define CLRB_CI_EXTERNAL_CURRENT_LIMIT_PIN      6
// clamp limits
`define CLRB_FAST_CHARGE_CURRENT_CODE_MAX     6'h2C
`define CLRB_FAST_CHARGE_CURRENT_CODE_MIN     6'h02
`define CLRB_VIN_MAX      5'h10
`endif

// [clrb_pkg.sv]
package clrb_pkg;
  // register access request from the serial engine
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } clrb_req_t;
  // effective settings passed to regulation logic
  typedef struct packed {
    logic [7:0] cell_regulation_voltage_code;
    logic       high_impedance_enable;
    logic       current_limit_pin_enable;
    logic [5:0] fast_charge_current_code;
    logic       battery_discharge_load_enable;
    logic       pulse_mode_out_of_audio_disable;
    logic [4:0] input_voltage_limit_code;
  } clrb_cfg_t;
endpackage

// [clrb_clamp.sv]
`timescale 1ns/10ps
`default_nettype none
`include "clrb_params.svh"
// saturates a code into [lo, hi]
module clrb_clamp
  import clrb_pkg::*;
#(
  parameter int W = 6
)(
  input  wire logic [W-1:0] raw,
  input  wire logic [W-1:0] lo,
  input  wire logic [W-1:0] hi,
  output logic      [W-1:0] eff
);
  always_comb
  begin
    if (raw > hi)
      eff = hi;
    else if (raw < lo)
      eff = lo;
    else
      eff = raw;
  end
endmodule
`default_nettype wire

// [clrb_regs.sv]
// Function
// - cell voltage code means 3.40 V plus 5 mV per count, default 4.20 V
// - cell voltage register resets to A0h, restored by register reset and watchdog
// - charge current register resets to 5Eh, fully restored by both resets
// - bit 6 enables external current limit pin; zero ignores it
// - charge current code 50 mA per count; bit 7 enables high impedance
// - charge current code clamped to 2Ch maximum and 100 mA minimum
// - input voltage register resets to 84h; bits 7,6 restored by both
// - plug-in reset bit set restores input voltage limit after detection
// - battery discharge load follows bit 6, default off
// - out-of-audio disable bit survives watchdog, cleared by register reset
// - input voltage code 3.9 V plus 100 mV per count, kept through watchdog
// - input voltage code above 10h clamped to 5.5 V setting
// - watchdog expiry restores defaults except fields marked as kept
// - undefined address answered with not-acknowledge; sequential access supported
`timescale 1ns/10ps
`default_nettype none
`include "clrb_params.svh"
module clrb_regs
  import clrb_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire clrb_req_t  req,
  input  wire logic       register_reset,
  input  wire logic       watchdog_expired,
  input  wire logic       source_detect_done,
  output clrb_req_t       unused_echo,
  output logic      [7:0] rdata,
  output logic            ack,
  output logic            nack,
  output clrb_cfg_t       cfg
);
  logic [7:0] cell_voltage_limit;
  logic [7:0] charge_current_limit;
  logic [7:0] input_voltage_limit;
  logic       hit;
  logic [5:0] fast_charge_current_code_eff;
  logic [4:0] vin_eff;
  logic [7:0] cfg_cell;
  logic       cfg_hiz;
  logic       cfg_external_current_limit_pin;
  logic [5:0] cfg_fast_charge_current_code;
  logic       cfg_dischg;
  logic       cfg_ooa;
  logic [4:0] cfg_vin;
  // reset image held as a vector so its upper field can be sliced at full width
  localparam logic [7:0] iv_reset_image = `CLRB_RST_IN_V;

  // ==========================================================
  // address decode
  assign hit = (req.addr <= `CLRB_LAST_OFS);

  // ==========================================================
  // cell voltage register
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      cell_voltage_limit <= `CLRB_RST_CELL_V;
    else if (register_reset || watchdog_expired)
      cell_voltage_limit <= `CLRB_RST_CELL_V;
    else if (req.wr && req.addr == `CLRB_OFS_CELL_V)
      cell_voltage_limit <= req.wdata;
  end

  // ==========================================================
  // charge current register
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      charge_current_limit <= `CLRB_RST_CHG_I;
    else if (register_reset || watchdog_expired)
      charge_current_limit <= `CLRB_RST_CHG_I;
    else if (req.wr && req.addr == `CLRB_OFS_CHG_I)
      charge_current_limit <= req.wdata;
  end

  // ==========================================================
  // input voltage register, split by which reset restores each field
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      input_voltage_limit <= `CLRB_RST_IN_V;
    else if (register_reset)
      input_voltage_limit <= `CLRB_RST_IN_V;
    else if (watchdog_expired)
      // low six bits survive the watchdog
      input_voltage_limit <= {iv_reset_image[7:6], input_voltage_limit[5:0]};
    else if (req.wr && req.addr == `CLRB_OFS_IN_V)
      input_voltage_limit <= req.wdata;
    else if (source_detect_done && input_voltage_limit[`CLRB_IV_PLUGRST])
      // host write in the same cycle wins over the plug-in restore
      input_voltage_limit[4:0] <= 5'(`CLRB_RST_IN_V);
  end

  // ==========================================================
  // acknowledge for mapped addresses
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      ack <= 1'b0;
    else
      ack <= (req.wr || req.rd) && hit;
  end

  // ==========================================================
  // refusal for unmapped addresses; nothing is stored for them
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      nack <= 1'b0;
    else
      nack <= (req.wr || req.rd) && !hit;
  end

  // ==========================================================
  // read data; raw codes, held until the next mapped read
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      rdata <= 8'h00;
    else if (req.rd && hit)
    begin
      case (req.addr)
        `CLRB_OFS_CELL_V: rdata <= cell_voltage_limit;
        `CLRB_OFS_CHG_I:  rdata <= charge_current_limit;
        default:          rdata <= input_voltage_limit;
      endcase
    end
  end

  // ==========================================================
  // clamping on the effective values only
  clrb_clamp #(.W(6)) u_fast_charge_current_code_clamp (
    .raw (charge_current_limit[5:0]),
    .lo  (`CLRB_FAST_CHARGE_CURRENT_CODE_MIN),
    .hi  (`CLRB_FAST_CHARGE_CURRENT_CODE_MAX),
    .eff (fast_charge_current_code_eff)
  );

  clrb_clamp #(.W(5)) u_vin_clamp (
    .raw (input_voltage_limit[4:0]),
    .lo  (5'h00),
    .hi  (`CLRB_VIN_MAX),
    .eff (vin_eff)
  );

  // ==========================================================
  // debug copy of the request, one cycle late
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      unused_echo <= '0;
    else
      unused_echo <= req;
  end

  // ==========================================================
  // cell regulation voltage setting
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      cfg_cell <= 8'h00;
    else
      cfg_cell <= cell_voltage_limit;
  end

  // ==========================================================
  // high impedance enable
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      cfg_hiz <= 1'b0;
    else
      cfg_hiz <= charge_current_limit[`CLRB_CI_HIZ];
  end

  // ==========================================================
  // external current limit pin enable
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      cfg_external_current_limit_pin <= 1'b0;
    else
      cfg_external_current_limit_pin <= charge_current_limit[`CLRB_CI_EXTERNAL_CURRENT_LIMIT_PIN];
  end

  // ==========================================================
  // fast charge current, clamped to 02h..2Ch; reset loads 00h, below that range
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      cfg_fast_charge_current_code <= 6'h00;
    else
      cfg_fast_charge_current_code <= fast_charge_current_code_eff;
  end

  // ==========================================================
  // battery discharge load
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      cfg_dischg <= 1'b0;
    else
      cfg_dischg <= input_voltage_limit[`CLRB_IV_DISCHG];
  end

  // ==========================================================
  // out-of-audio disable in pulse mode
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      cfg_ooa <= 1'b0;
    else
      cfg_ooa <= input_voltage_limit[`CLRB_IV_OOA_DIS];
  end

  // ==========================================================
  // input voltage limit, clamped
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      cfg_vin <= 5'h00;
    else
      cfg_vin <= vin_eff;
  end

  // ==========================================================
  // settings bundle; pure wiring of the flops above, no logic
  always_comb
  begin
    cfg                                 = '0;
    cfg.cell_regulation_voltage_code    = cfg_cell;
    cfg.high_impedance_enable           = cfg_hiz;
    cfg.current_limit_pin_enable        = cfg_external_current_limit_pin;
    cfg.fast_charge_current_code        = cfg_fast_charge_current_code;
    cfg.battery_discharge_load_enable   = cfg_dischg;
    cfg.pulse_mode_out_of_audio_disable = cfg_ooa;
    cfg.input_voltage_limit_code        = cfg_vin;
  end
endmodule
`default_nettype wire

// [clrb_regs_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
module clrb_regs_chk
  import clrb_pkg::*;
(
  input wire logic      clock,
  input wire logic      rstn,
  input wire clrb_req_t req,
  input wire logic      register_reset,
  input wire logic      watchdog_expired,
  input wire logic      ack,
  input wire logic      nack,
  input wire clrb_cfg_t cfg
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  logic go;
  assign go = req.wr | req.rd;
  // ====
  // access answers
  a_ack_map: assert property (go && req.addr <= 8'h02 |=> ack && !nack)
    else $error("mapped access not acked");
  a_nack_unmap: assert property (go && req.addr > 8'h02 |=> nack && !ack)
    else $error("unmapped access not refused");
  a_idle_quiet: assert property (!go |=> !ack && !nack)
    else $error("answer without request");
  // ====
  // clamped settings
  a_cur_max: assert property (cfg.fast_charge_current_code <= 6'h2C)
    else $error("current code above max");
  a_cur_min: assert property ($past(rstn) |-> cfg.fast_charge_current_code >= 6'h02)
    else $error("current code below min");
  a_vin_max: assert property (cfg.input_voltage_limit_code <= 5'h10)
    else $error("input voltage code above max");
  // ====
  // write and restore paths; reset beats a same-cycle write
  a_cell_write: assert property (
    req.wr && req.addr == 8'h00 && !register_reset && !watchdog_expired
    |=> ##1 cfg.cell_regulation_voltage_code == $past(req.wdata, 2))
    else $error("cell code not written");
  a_rst_defaults: assert property (
    register_reset |=> ##1 cfg.cell_regulation_voltage_code == 8'hA0
    && !cfg.battery_discharge_load_enable && !cfg.pulse_mode_out_of_audio_disable)
    else $error("register reset left fields");
  a_wd_defaults: assert property (
    watchdog_expired |=> ##1 !cfg.high_impedance_enable
    && cfg.current_limit_pin_enable && cfg.fast_charge_current_code == 6'h1E)
    else $error("watchdog left current fields");
  c_wd: cover property (watchdog_expired);
  c_rr: cover property (register_reset);
  c_nack: cover property (nack);
endmodule
bind clrb_regs clrb_regs_chk chk_u (.clock, .rstn, .req, .register_reset, .watchdog_expired,
  .ack, .nack, .cfg);
`default_nettype wire

// [clrb_host.sv]
`timescale 1ns/10ps
`default_nettype none
module clrb_host
  import clrb_pkg::*;
(
  input wire logic       clock,
  input wire logic       ack,
  input wire logic       nack,
  input wire logic [7:0] rdata,
  output clrb_req_t      req
);
  initial req = '0;
  // one byte access; serial engine steps addresses itself for multi-byte runs
  task automatic xfer(input logic w, input logic [7:0] a, d,
                      output logic [7:0] q, output logic [1:0] k);
    @(negedge clock);
    req = '{w, !w, a, d};
    @(negedge clock);
    req = '0;
    k = {ack, nack};
    q = rdata;
  endtask
endmodule
`default_nettype wire

// [charger_limit_register_bank_test.sv]
`timescale 1ns/10ps
`default_nettype none
module charger_limit_register_bank_test
  import clrb_pkg::*;
;
  logic       clock, rstn, register_reset, watchdog_expired, source_detect_done, ack, nack;
  logic [7:0] q, rdata;
  logic [1:0] k;
  int         err_total, total_checks, cyc;
  clrb_req_t  req;
  clrb_cfg_t  cfg;
  clrb_regs dut_u (.clock, .rstn, .req, .register_reset, .watchdog_expired,
    .source_detect_done, .unused_echo(), .rdata, .ack, .nack, .cfg);
  clrb_host host_u (.clock, .ack, .nack, .rdata, .req);
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // ====
  // hang guard
  always @(posedge clock)
  begin
    cyc++;
    if (cyc > 3000)
    begin
      err_total++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (err_total == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [7:0] s, e);
    total_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("MISMATCH %0t got %h exp %h", $time, s, e);
    end
  endtask
  task automatic rd(input logic [7:0] a, e);
    host_u.xfer(1'b0, a, 8'h00, q, k);
    check({6'h0, k}, 8'h02);
    check(q, e);
  endtask
  task automatic wr(input logic [7:0] a, d);
    host_u.xfer(1'b1, a, d, q, k);
  endtask
  task automatic pulse(input logic [2:0] v);
    @(negedge clock);
    {register_reset, watchdog_expired, source_detect_done} = v;
    @(negedge clock);
    {register_reset, watchdog_expired, source_detect_done} = 3'h0;
  endtask
  // ====
  // scenarios
  task automatic t_reset();
    rd(8'h00, 8'hA0);
    rd(8'h01, 8'h5E);
    rd(8'h02, 8'h84);
    check(cfg.cell_regulation_voltage_code, 8'hA0);
    check({1'b0, cfg.current_limit_pin_enable, cfg.fast_charge_current_code}, 8'h5E);
    check({3'h0, cfg.input_voltage_limit_code}, 8'h04);
  endtask
  task automatic t_clamp();
    wr(8'h01, 8'hFF);
    rd(8'h01, 8'hFF);
    check({cfg.high_impedance_enable, 1'b0, cfg.fast_charge_current_code}, 8'hAC);
    wr(8'h01, 8'h01);
    rd(8'h01, 8'h01);
    check({1'b0, cfg.current_limit_pin_enable, cfg.fast_charge_current_code}, 8'h02);
    wr(8'h02, 8'h5F);
    rd(8'h02, 8'h5F);
    check({cfg.battery_discharge_load_enable, 2'h0, cfg.input_voltage_limit_code}, 8'h90);
    host_u.xfer(1'b1, 8'h03, 8'h55, q, k);
    check({6'h0, k}, 8'h01);
    check(q, 8'h5F);
  endtask
  task automatic t_plug();
    pulse(3'h1);
    rd(8'h02, 8'h5F);
    wr(8'h02, 8'hBF);
    pulse(3'h1);
    rd(8'h02, 8'hA4);
  endtask
  task automatic t_resets();
    wr(8'h02, 8'h6B);
    wr(8'h00, 8'h33);
    pulse(3'h2);
    rd(8'h02, 8'hAB);
    rd(8'h00, 8'hA0);
    rd(8'h01, 8'h5E);
    pulse(3'h4);
    rd(8'h02, 8'h84);
  endtask
  initial
  begin
    rstn = 1'b0;
    {register_reset, watchdog_expired, source_detect_done} = 3'h0;
    repeat (5) @(posedge clock);
    @(negedge clock);
    rstn = 1'b1;
    t_reset();
    t_clamp();
    t_plug();
    t_resets();
    stop_test();
  end
endmodule
`default_nettype wire
